// [src/rtc_ctrl_regs.svh]
// Register map, field positions, reset values and timing for the RTC control block.
// Assumes an APB slave with 32-bit words; register index times four is the byte address.
`ifndef RTC_CTRL_REGS_SVH
`define RTC_CTRL_REGS_SVH

// Register indices (byte address is index times four)
`define IDX_CONTROL_ZERO 20'hFFF9D
`define IDX_CONTROL_ONE 20'hFFF9E
`define IDX_STATUS 20'hFFFA0
`define IDX_MASK 20'hFFFA1
`define IDX_SECOND 20'hFFFA2
`define IDX_MINUTE 20'hFFFA3
`define IDX_HOUR 20'hFFFA4
`define IDX_DAY 20'hFFFA5

// Control zero fields
`define C0_RUN_BIT 7
`define C0_OE_BIT 5
`define C0_FMT_BIT 3
`define C0_PER_MSB 2
`define C0_PER_LSB 0
`define C0_WRITE_MASK 8'hAF
`define C0_RESET 8'h00
// Control one fields
`define C1_WAIT_BIT 0
`define C1_RESET 8'h00
// Status and mask
`define ST_EVENT_BIT 0
`define MASK_RESET 1'b1

// Time counter values (BCD)
`define BCD_ZERO 8'h00
`define BCD_ONE 8'h01
`define BCD_59 8'h59
`define BCD_23 8'h23
`define BCD_11 8'h11
`define BCD_12 8'h12
`define BCD_31 8'h31
`define PM_BIT 5
`define HOUR_RESET 8'h12
`define DAY_RESET 8'h01

// Timing
`define CLK_HZ 25000000
`define HALF_SEC_MS 500
`define HALF_SEC_CYCLES (`CLK_HZ / 1000 * `HALF_SEC_MS)

`endif

// [src/rtc_ctrl_pkg.sv]
// Types shared by the RTC control block.
// Assumes nothing beyond a SystemVerilog compiler.
package rtc_ctrl_pkg;
  typedef logic [7:0] bcd_t;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    PER_OFF = 3'b000,
    PER_HALF_SEC = 3'b001,
    PER_SECOND = 3'b010,
    PER_MINUTE = 3'b011,
    PER_HOUR = 3'b100,
    PER_DAY = 3'b101,
    PER_MONTH_A = 3'b110,
    PER_MONTH_B = 3'b111
  } period_sel_t;
endpackage

// [src/rtc_control_reg0_logic.sv]
// RTC run control, 1 Hz pin, 12/24-hour time counting and constant-period interrupt.
// Assumes an APB master on pclk; all other inputs synchronous to pclk.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "rtc_ctrl_regs.svh"
`default_nettype none

module rtc_control_reg0_logic #(
  parameter int unsigned HALF_SEC_CYCLES = `HALF_SEC_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire rtc_ctrl_pkg::word_t paddr,
  input wire rtc_ctrl_pkg::word_t pwdata,
  output rtc_ctrl_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  // Pins and interrupt
  output logic one_hz_pin,
  output logic periodic_irq,
  output logic irq
);
  import rtc_ctrl_pkg::*;

  logic [7:0] ctrl0_q;
  logic wait_q;
  logic event_q;
  logic mask_q;
  bcd_t sec_q, min_q, hour_q, day_q;
  logic [23:0] half_cnt_q;
  logic phase_q;
  logic one_hz_q;
  logic pulse_q;
  word_t rdata_q;

  // Register index match; upper address bits must be clear
  function automatic logic hit(input word_t a, input logic [19:0] idx);
    return (a[31:22] == 10'h000) && (a[21:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // BCD increment of a two-digit value
  function automatic bcd_t bcd_inc(input bcd_t v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Next hour in either format
  function automatic bcd_t hour_next(input bcd_t h, input logic fmt24);
    bcd_t low;
    low = {3'b000, h[4:0]};
    if (fmt24) begin
      return (h == `BCD_23) ? `BCD_ZERO : bcd_inc(h);
    end
    if (low == `BCD_11) begin
      return {2'b00, ~h[`PM_BIT], 5'h12};
    end
    if (low == `BCD_12) begin
      return {2'b00, h[`PM_BIT], 5'h01};
    end
    return {2'b00, h[`PM_BIT], 5'(bcd_inc(low))};
  endfunction

  // Field views
  logic run, oe, fmt24;
  period_sel_t per;
  assign run = ctrl0_q[`C0_RUN_BIT];
  assign oe = ctrl0_q[`C0_OE_BIT];
  assign fmt24 = ctrl0_q[`C0_FMT_BIT];
  assign per = period_sel_t'(ctrl0_q[`C0_PER_MSB:`C0_PER_LSB]);

  // Bus decode
  logic setup, acc, wr, rd, mapped;
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign mapped = hit(paddr, `IDX_CONTROL_ZERO) || hit(paddr, `IDX_CONTROL_ONE) ||
                  hit(paddr, `IDX_STATUS) || hit(paddr, `IDX_MASK) || hit(paddr, `IDX_SECOND) ||
                  hit(paddr, `IDX_MINUTE) || hit(paddr, `IDX_HOUR) || hit(paddr, `IDX_DAY);

  // Zero-wait slave; unmapped accesses report an error
  assign pready = acc;
  assign pslverr = acc && !mapped;
  assign prdata = rdata_q;

  // Counting advances only when running and not held by counter wait
  logic counting;
  assign counting = run && !wait_q;

  // Timebase and carries
  logic half_tick, sec_tick, sec_wrap, min_wrap, hour_roll, day_roll;
  bcd_t hour_n, day_n;
  assign half_tick = counting && (half_cnt_q == 24'(HALF_SEC_CYCLES - 1));
  assign sec_tick = half_tick && phase_q;
  assign sec_wrap = (sec_q == `BCD_59);
  assign min_wrap = (min_q == `BCD_59);
  assign hour_roll = sec_tick && sec_wrap && min_wrap;
  assign hour_n = hour_next(hour_q, fmt24);
  // Midnight is 00H in 24-hour and 12H AM in 12-hour format
  assign day_roll = hour_roll && (fmt24 ? (hour_n == `BCD_ZERO) : (hour_n == `BCD_12));
  assign day_n = (day_q == `BCD_31) ? `BCD_ONE : bcd_inc(day_q);

  // Periodic source select
  logic fire;
  always_comb begin
    unique case (per)
      PER_OFF: fire = 1'b0;
      PER_HALF_SEC: fire = half_tick;
      PER_SECOND: fire = sec_tick;
      PER_MINUTE: fire = sec_tick && sec_wrap;
      PER_HOUR: fire = hour_roll;
      PER_DAY: fire = day_roll;
      PER_MONTH_A, PER_MONTH_B: fire = day_roll && (day_n == `BCD_ONE);
    endcase
  end

  // Control zero; reserved bits 4 and 6 are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= `C0_RESET;
    end else if (wr && hit(paddr, `IDX_CONTROL_ZERO)) begin
      ctrl0_q <= pwdata[7:0] & `C0_WRITE_MASK;
    end
  end

  // Control one: counter wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 1'(`C1_RESET);
    end else if (wr && hit(paddr, `IDX_CONTROL_ONE)) begin
      wait_q <= pwdata[`C1_WAIT_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `MASK_RESET;
    end else if (wr && hit(paddr, `IDX_MASK)) begin
      mask_q <= pwdata[`ST_EVENT_BIT];
    end
  end

  // Half-second divider; restarts whenever counting is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_q <= 24'h000000;
      phase_q <= 1'b0;
    end else if (!counting) begin
      half_cnt_q <= 24'h000000;
    end else if (half_tick) begin
      half_cnt_q <= 24'h000000;
      phase_q <= ~phase_q;
    end else begin
      half_cnt_q <= half_cnt_q + 24'h000001;
    end
  end

  // 1 Hz pin: one toggle per half second, low while stopped or disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_hz_q <= 1'b0;
    end else if (!run || !oe) begin
      one_hz_q <= 1'b0;
    end else if (half_tick) begin
      one_hz_q <= ~one_hz_q;
    end
  end
  assign one_hz_pin = one_hz_q;

  // Time counters; a bus write wins over a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= `BCD_ZERO;
      min_q <= `BCD_ZERO;
      hour_q <= `HOUR_RESET;
      day_q <= `DAY_RESET;
    end else if (wr && (hit(paddr, `IDX_SECOND) || hit(paddr, `IDX_MINUTE) ||
                        hit(paddr, `IDX_HOUR) || hit(paddr, `IDX_DAY))) begin
      if (hit(paddr, `IDX_SECOND)) sec_q <= pwdata[7:0];
      if (hit(paddr, `IDX_MINUTE)) min_q <= pwdata[7:0];
      if (hit(paddr, `IDX_HOUR)) hour_q <= pwdata[7:0];
      if (hit(paddr, `IDX_DAY)) day_q <= pwdata[7:0];
    end else if (sec_tick) begin
      sec_q <= sec_wrap ? `BCD_ZERO : bcd_inc(sec_q);
      if (sec_wrap) min_q <= min_wrap ? `BCD_ZERO : bcd_inc(min_q);
      if (hour_roll) hour_q <= hour_n;
      if (day_roll) day_q <= day_n;
    end
  end

  // One-cycle periodic request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= fire;
    end
  end
  assign periodic_irq = pulse_q;

  // Sticky event flag, cleared by a status read; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= 1'b0;
    end else if (fire) begin
      event_q <= 1'b1;
    end else if (rd && hit(paddr, `IDX_STATUS)) begin
      event_q <= 1'b0;
    end
  end
  assign irq = event_q && !mask_q;

  // Read data captured in the setup cycle so it is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      rdata_q <= 32'h00000000;
      if (hit(paddr, `IDX_CONTROL_ZERO)) rdata_q[7:0] <= ctrl0_q;
      if (hit(paddr, `IDX_CONTROL_ONE)) rdata_q[`C1_WAIT_BIT] <= wait_q;
      // An event landing on the capture edge must be seen, or the clearing access would lose it
      if (hit(paddr, `IDX_STATUS)) rdata_q[`ST_EVENT_BIT] <= event_q || fire;
      if (hit(paddr, `IDX_MASK)) rdata_q[`ST_EVENT_BIT] <= mask_q;
      if (hit(paddr, `IDX_SECOND)) rdata_q[7:0] <= sec_q;
      if (hit(paddr, `IDX_MINUTE)) rdata_q[7:0] <= min_q;
      if (hit(paddr, `IDX_HOUR)) rdata_q[7:0] <= hour_q;
      if (hit(paddr, `IDX_DAY)) rdata_q[7:0] <= day_q;
    end
  end

endmodule

`default_nettype wire

// [sim/rtc_control_reg0_logic_chk.sv]
// Port-level assertions for the RTC control block.
// Assumes binding into rtc_control_reg0_logic; APB writes to control zero and the mask are shadowed here.
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl_chk (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire rtc_ctrl_pkg::word_t paddr,
  input wire rtc_ctrl_pkg::word_t pwdata,
  input wire rtc_ctrl_pkg::word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupt
  input wire logic one_hz_pin,
  input wire logic periodic_irq,
  input wire logic irq
);
  import rtc_ctrl_pkg::*;
  logic [7:0] c0_q;
  logic mask_q;
  wire logic wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of control zero, same edge as the real register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_q <= 8'h00;
    end else if (wr && paddr == 32'h003FFE74) begin
      c0_q <= pwdata[7:0];
    end
  end
  // Shadow of the mask; resets masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 1'b1;
    end else if (wr && paddr == 32'h003FFE84) begin
      mask_q <= pwdata[0];
    end
  end
  property p_ready; pready == (psel && penable); endproperty
  a_ready: assert property (p_ready) else $error("pready outside access phase");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access phase");
  property p_refuse; psel && penable && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  a_refuse: assert property (p_refuse) else $error("refused read returned data");
  property p_zero; psel && penable && !pwrite && paddr == 32'h003FFE74 |-> (prdata & 32'hFFFFFF50) == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("control zero reserved bits set");
  property p_pin; !(c0_q[7] && c0_q[5]) [*2] |-> !one_hz_pin; endproperty
  a_pin: assert property (p_pin) else $error("1 Hz pin active while off");
  property p_stop; !c0_q[7] [*2] |-> !periodic_irq; endproperty
  a_stop: assert property (p_stop) else $error("event while stopped");
  property p_off; (c0_q[2:0] == 3'b000) [*2] |-> !periodic_irq; endproperty
  a_off: assert property (p_off) else $error("event with period off");
  property p_pulse; periodic_irq |=> !periodic_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("event wider than one cycle");
  property p_irq_on; periodic_irq && !mask_q |-> irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("unmasked event without irq");
  property p_irq_mask; mask_q |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule
bind rtc_control_reg0_logic rtc_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .one_hz_pin(one_hz_pin), .periodic_irq(periodic_irq), .irq(irq));
`default_nettype wire

// [sim/tb_rtc_control_reg0_logic.sv]
// Self-checking bench for the RTC control block, driven over APB.
// Assumes the checker is bound; half second shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t %0h %0h", $time, g, e); end end
module tb_rtc_control_reg0_logic;
  import rtc_ctrl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, one_hz_pin, periodic_irq, irq, err;
  word_t paddr = 32'h0, pwdata = 32'h0, prdata, q;
  int n_errors = 0, tests_run = 0, np, nt;
  localparam word_t C0 = 32'h003FFE74, C1 = 32'h003FFE78, ST = 32'h003FFE80, MK = 32'h003FFE84;
  localparam word_t SC = 32'h003FFE88, MN = 32'h003FFE8C, HR = 32'h003FFE90, DY = 32'h003FFE94;
  word_t ra[6] = '{C0, C1, MK, HR, DY, ST}, rv[6] = '{0, 0, 1, 32'h12, 1, 0};
  word_t rc[4] = '{32'hA1, 32'hA0, 32'h82, 32'h00};
  int rp[4] = '{10, 0, 5, 0}, rt[4] = '{10, 10, 0, 0};
  word_t tc[5] = '{32'h83, 32'h84, 32'h8D, 32'h86, 32'h8F}, th[5] = '{32'h11, 32'h32, 32'h23, 32'h31, 32'h23};
  word_t td[5] = '{5, 5, 5, 32'h31, 32'h31}, eh[5] = '{32'h32, 32'h21, 0, 32'h12, 0}, ed[5] = '{5, 5, 6, 1, 1};
  rtc_control_reg0_logic #(.HALF_SEC_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .one_hz_pin(one_hz_pin), .periodic_irq(periodic_irq), .irq(irq));
  // 25 MHz clock
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input word_t a, input word_t d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      give_verdict();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for one periodic event
  task automatic wait_pulse();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (periodic_irq !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // Events and pin toggles over a window; any 40 cycles hold whole periods
  task automatic count(input int c);
    logic p;
    np = 0;
    nt = 0;
    p = one_hz_pin;
    repeat (c) begin
      @(posedge pclk);
      np += (periodic_irq === 1'b1);
      nt += (one_hz_pin !== p);
      p = one_hz_pin;
    end
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      xfer(0, ra[i], 0);
      `CK(q, rv[i])
    end
    xfer(1, C0, 32'hAF);
    xfer(0, C0, 0);
    `CK(q, 32'hAF)
    xfer(1, 32'h003FFE7C, 32'h55);
    `CK(err, 1'b1)
    xfer(0, 32'h003FFE7C, 0);
    `CK(q, 32'h0)
    xfer(1, C0, 32'h80);
    xfer(1, C1, 32'h01);
    xfer(1, SC, 32'h10);
    repeat (20) @(posedge pclk);
    xfer(0, SC, 0);
    `CK(q, 32'h10)
    xfer(1, C1, 32'h00);
    repeat (18) @(posedge pclk);
    xfer(0, SC, 0);
    `CK(q, 32'h12)
    foreach (rc[i]) begin
      xfer(1, C0, rc[i]);
      repeat (2) @(posedge pclk);
      count(40);
      `CK(np, rp[i])
      `CK(nt, rt[i])
    end
    foreach (tc[i]) begin
      xfer(1, SC, 32'h59);
      xfer(1, MN, 32'h59);
      xfer(1, HR, th[i]);
      xfer(1, DY, td[i]);
      xfer(1, C0, tc[i]);
      wait_pulse();
      xfer(1, C0, 32'h0);
      xfer(0, HR, 0);
      `CK(q, eh[i])
      xfer(0, DY, 0);
      `CK(q, ed[i])
    end
    xfer(1, C0, 32'h81);
    wait_pulse();
    `CK(irq, 1'b0)
    xfer(0, ST, 0);
    `CK(q, 32'h1)
    xfer(1, MK, 32'h1);
    xfer(1, C0, 32'h82);
    xfer(0, ST, 0);
    xfer(1, MK, 32'h0);
    wait_pulse();
    `CK(irq, 1'b1)
    xfer(0, ST, 0);
    `CK(q, 32'h1)
    @(negedge pclk);
    `CK(irq, 1'b0)
    give_verdict();
  end
endmodule
`default_nettype wire
